/* common/xbc_pkg.sv */
// Purpose: shared constants and types for the external memory bus control block
// Assumes: 16-bit data address space, 8-bit multiplexed bus
// Notes: byte addresses of the register words are chosen here
package xbc_pkg;
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	localparam int ENABLE_BIT = 7;
	localparam int LIMIT_LSB = 4;
	localparam int UPPER_WS_LSB = 2;
	localparam int LOWER_WS_LSB = 0;
	localparam int KEEPER_BIT = 7;
	localparam int MASK_LSB = 0;

	localparam logic [7:0] CTRL_A_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_WRITABLE = 8'h87;

	localparam logic [15:0] FIRST_EXT_ADDR = 16'h2200;
	localparam int SECTOR_SHIFT = 13;
	localparam logic [2:0] LIMIT_SPLIT_MIN = 3'h2;
	localparam logic [2:0] MASK_ALL = 3'h7;
	localparam int HI_PINS = 8;

	localparam logic [1:0] WS_NONE = 2'h0;
	localparam logic [1:0] WS_ONE = 2'h1;
	localparam logic [1:0] WS_TWO = 2'h2;
	localparam logic [1:0] WS_TWO_GAP = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_STRB = 2'b10,
		ST_GAP = 2'b11
	} xbc_state_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} xbc_req_type;

	typedef struct packed {
		logic [7:0] a_out;
		logic [7:0] a_dir;
		logic [7:0] c_out;
		logic [7:0] c_dir;
		logic [2:0] g_out;
		logic [2:0] g_dir;
	} xbc_port_type;

	typedef struct packed {
		logic [7:0] ad_out;
		logic [7:0] ad_oe;
		logic ad_keep;
		logic [7:0] hi_out;
		logic [7:0] hi_oe;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic [2:0] ctl_oe;
	} xbc_pins_type;
endpackage

/* hw/xbc_ctrl.sv */
// Purpose: external memory bus control with AHB-Lite register access
// Assumes: core access requests are synchronous to hclk
// Notes: zero-wait AHB slave, OKAY response always
//
// Overview of operation
// - enable bit hands bus pins to memory
// - enable clear returns pins to port
// - limit field sets upper sector start
// - limit resets to zero, one sector
// - single sector uses upper wait-state field
// - bits 3:2 set upper sector waits
// - bits 1:0 set lower sector waits
// - codes 00/01/10 add 0/1/2 strobe cycles
// - code 11 adds two plus idle gap
// - keeper holds last driven bus value
// - keeper works even with bus disabled
// - keeper bit clear stops holding
// - control b bits 6:3 read zero
// - mask zero drives all eight high pins
// - each mask step up to 6 releases next top pin; 7 frees all
// - low internal addresses never go external
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module xbc_ctrl #(
	parameter int HI_ADDR_PINS = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire xbc_pkg::xbc_req_type core_req,
	output logic core_ack,
	output logic [7:0] core_rdata,
	input wire xbc_pkg::xbc_port_type port_norm,
	input wire logic [7:0] ad_in,
	output xbc_pkg::xbc_pins_type pins
);
	if (HI_ADDR_PINS != xbc_pkg::HI_PINS) begin : g_bad_pins
		$error("xbc_ctrl serves exactly eight high address pins");
	end

	// register file and bus slave state
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic [7:0] next_ctrl_a;
	logic [7:0] next_ctrl_b;
	logic wr_pend;
	logic next_wr_pend;
	logic [7:0] wr_addr;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;

	// access sequencer state
	xbc_pkg::xbc_state_type st;
	xbc_pkg::xbc_state_type next_st;
	logic [1:0] ws_code;
	logic [1:0] next_ws_code;
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic [15:0] acc_addr;
	logic [15:0] next_acc_addr;
	logic [7:0] acc_wdata;
	logic [7:0] next_acc_wdata;
	logic acc_write;
	logic next_acc_write;
	logic acc_upper;
	logic next_acc_upper;
	logic next_core_ack;
	logic [7:0] next_core_rdata;
	logic [7:0] last_ad;
	logic [7:0] next_last_ad;

	// decoded controls
	logic enable;
	logic keeper_on;
	logic [2:0] limit;
	logic [2:0] mask;
	logic [15:0] upper_start;
	logic req_upper;
	logic [3:0] hi_bits;
	logic strobe;
	logic addr_phase;

	assign enable = ctrl_a[xbc_pkg::ENABLE_BIT];
	assign keeper_on = ctrl_b[xbc_pkg::KEEPER_BIT];
	assign limit = ctrl_a[xbc_pkg::LIMIT_LSB +: 3];
	assign mask = ctrl_b[xbc_pkg::MASK_LSB +: 3];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && hready && htrans[1];
	assign strobe = (st == xbc_pkg::ST_STRB);

	always_comb begin
		next_wr_pend = addr_phase && hwrite;
		next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
		next_ctrl_a = ctrl_a;
		next_ctrl_b = ctrl_b;
		if (wr_pend && wr_addr == xbc_pkg::ADDR_CTRL_A) begin
			next_ctrl_a = hwdata[7:0];
		end
		if (wr_pend && wr_addr == xbc_pkg::ADDR_CTRL_B) begin
			next_ctrl_b = hwdata[7:0] & xbc_pkg::CTRL_B_WRITABLE;
		end
		// forwarded values so a read right after a write sees it
		next_hrdata = 32'h0000_0000;
		if (addr_phase && !hwrite) begin
			case (haddr[7:0])
				xbc_pkg::ADDR_CTRL_A: begin
					next_hrdata = {24'h00_0000, next_ctrl_a};
				end
				xbc_pkg::ADDR_CTRL_B: begin
					next_hrdata = {24'h00_0000, next_ctrl_b};
				end
				xbc_pkg::ADDR_STATUS: begin
					next_hrdata = {27'h000_0000, acc_upper, ws_code, st};
				end
				default: begin
					next_hrdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_a <= xbc_pkg::CTRL_A_RESET;
			ctrl_b <= xbc_pkg::CTRL_B_RESET;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			ctrl_a <= next_ctrl_a;
			ctrl_b <= next_ctrl_b;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
		end
	end

	// sector split: codes below two leave one upper sector
	always_comb begin
		if (limit < xbc_pkg::LIMIT_SPLIT_MIN) begin
			upper_start = xbc_pkg::FIRST_EXT_ADDR;
		end else begin
			upper_start = {limit, 13'h0000};
		end
		req_upper = (core_req.addr >= upper_start);
	end

	always_comb begin
		next_st = st;
		next_ws_code = ws_code;
		next_cnt = cnt;
		next_acc_addr = acc_addr;
		next_acc_wdata = acc_wdata;
		next_acc_write = acc_write;
		next_acc_upper = acc_upper;
		next_core_ack = 1'b0;
		next_core_rdata = core_rdata;
		case (st)
			xbc_pkg::ST_IDLE: begin
				if (core_req.valid) begin
					if (!enable || core_req.addr < xbc_pkg::FIRST_EXT_ADDR) begin
						next_core_ack = 1'b1;
					end else begin
						next_st = xbc_pkg::ST_ADDR;
						next_acc_addr = core_req.addr;
						next_acc_wdata = core_req.wdata;
						next_acc_write = core_req.write;
						next_acc_upper = req_upper;
						if (req_upper) begin
							next_ws_code = ctrl_a[xbc_pkg::UPPER_WS_LSB +: 2];
						end else begin
							next_ws_code = ctrl_a[xbc_pkg::LOWER_WS_LSB +: 2];
						end
					end
				end
			end
			xbc_pkg::ST_ADDR: begin
				next_st = xbc_pkg::ST_STRB;
				case (ws_code)
					xbc_pkg::WS_NONE: begin
						next_cnt = 2'h0;
					end
					xbc_pkg::WS_ONE: begin
						next_cnt = 2'h1;
					end
					default: begin
						next_cnt = 2'h2;
					end
				endcase
			end
			xbc_pkg::ST_STRB: begin
				if (cnt == 2'h0) begin
					next_core_ack = 1'b1;
					if (!acc_write) begin
						next_core_rdata = ad_in;
					end
					if (ws_code == xbc_pkg::WS_TWO_GAP) begin
						next_st = xbc_pkg::ST_GAP;
					end else begin
						next_st = xbc_pkg::ST_IDLE;
					end
				end else begin
					next_cnt = cnt - 2'h1;
				end
			end
			xbc_pkg::ST_GAP: begin
				next_st = xbc_pkg::ST_IDLE;
			end
			default: begin
				next_st = xbc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= xbc_pkg::ST_IDLE;
			ws_code <= xbc_pkg::WS_NONE;
			cnt <= 2'h0;
			acc_addr <= 16'h0000;
			acc_wdata <= 8'h00;
			acc_write <= 1'b0;
			acc_upper <= 1'b0;
			core_ack <= 1'b0;
			core_rdata <= 8'h00;
			last_ad <= 8'h00;
		end else begin
			st <= next_st;
			ws_code <= next_ws_code;
			cnt <= next_cnt;
			acc_addr <= next_acc_addr;
			acc_wdata <= next_acc_wdata;
			acc_write <= next_acc_write;
			acc_upper <= next_acc_upper;
			core_ack <= next_core_ack;
			core_rdata <= next_core_rdata;
			last_ad <= next_last_ad;
		end
	end

	// number of high pins kept for address; code 7 frees all
	always_comb begin
		if (mask == xbc_pkg::MASK_ALL) begin
			hi_bits = 4'h0;
		end else begin
			hi_bits = 4'h8 - {1'b0, mask};
		end
	end

	always_comb begin
		pins.ad_out = port_norm.a_out;
		pins.ad_oe = port_norm.a_dir;
		pins.hi_out = port_norm.c_out;
		pins.hi_oe = port_norm.c_dir;
		{pins.ale, pins.rd_n, pins.wr_n} = port_norm.g_out;
		pins.ctl_oe = port_norm.g_dir;
		if (enable) begin
			pins.ctl_oe = 3'b111;
			pins.ale = (st == xbc_pkg::ST_ADDR);
			pins.rd_n = !(strobe && !acc_write);
			pins.wr_n = !(strobe && acc_write);
			pins.ad_out = last_ad;
			pins.ad_oe = 8'h00;
			if (st == xbc_pkg::ST_ADDR) begin
				pins.ad_out = acc_addr[7:0];
				pins.ad_oe = 8'hFF;
			end else if (strobe && acc_write) begin
				pins.ad_out = acc_wdata;
				pins.ad_oe = 8'hFF;
			end
			for (int i = 0; i < xbc_pkg::HI_PINS; i++) begin
				if (i < int'(hi_bits)) begin
					pins.hi_out[i] = acc_addr[8 + i];
					pins.hi_oe[i] = 1'b1;
				end
			end
		end
		if (pins.ad_oe == 8'h00) begin
			pins.ad_out = last_ad;
		end
		pins.ad_keep = keeper_on && (pins.ad_oe == 8'h00);
	end

	always_comb begin
		next_last_ad = last_ad;
		for (int i = 0; i < 8; i++) begin
			if (pins.ad_oe[i]) begin
				next_last_ad[i] = pins.ad_out[i];
			end
		end
	end

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic rd_b_phase;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_b_phase <= 1'b0;
		end else begin
			rd_b_phase <= addr_phase && !hwrite && haddr[7:0] == xbc_pkg::ADDR_CTRL_B;
		end
	end

	AST_ENABLE_PINS: assert property (enable |-> pins.ctl_oe == 3'b111
		&& !(pins.rd_n && pins.wr_n && strobe))
		else $error("enabled bus does not own strobe pins");
	AST_DISABLE_PORT: assert property (!enable |-> pins.ad_oe == port_norm.a_dir
		&& pins.hi_oe == port_norm.c_dir && pins.ctl_oe == port_norm.g_dir)
		else $error("disabled bus does not return pins to port");
	AST_SINGLE_SECTOR: assert property ((st == xbc_pkg::ST_IDLE && next_st == xbc_pkg::ST_ADDR
		&& limit < 3'h2) |=> ws_code == $past(ctrl_a[3:2]) && acc_upper)
		else $error("single sector not using upper wait field");
	AST_ONE_WAIT: assert property ((st == xbc_pkg::ST_ADDR && ws_code == 2'h1)
		|=> strobe [*2] ##1 !strobe)
		else $error("one wait-state strobe not two cycles");
	AST_GAP_WAIT: assert property ((st == xbc_pkg::ST_ADDR && ws_code == 2'h3)
		|=> strobe [*3] ##1 (st == xbc_pkg::ST_GAP && !pins.ale) ##1 !pins.ale)
		else $error("code three lacks strobe stretch or gap");
	AST_KEEPER_HOLD: assert property ((keeper_on && $past(pins.ad_oe) == 8'hFF && pins.ad_oe == 8'h00)
		|-> pins.ad_keep && pins.ad_out == $past(pins.ad_out))
		else $error("keeper does not hold last driven value");
	AST_KEEPER_OFF: assert property (!keeper_on |-> !pins.ad_keep)
		else $error("keeper active while disabled");
	AST_RESERVED_ZERO: assert property (rd_b_phase |-> hrdata[6:3] == 4'h0)
		else $error("reserved control bits read nonzero");
	AST_FULL_HIGH: assert property ((enable && mask == 3'h0) |-> pins.hi_oe == 8'hFF)
		else $error("high address byte not fully driven");
	AST_MASK_ALL: assert property ((enable && mask == 3'h7) |-> pins.hi_oe == port_norm.c_dir)
		else $error("full mask still drives high address");
	AST_INTERNAL: assert property ((st == xbc_pkg::ST_IDLE && core_req.valid
		&& core_req.addr < 16'h2200) |=> core_ack && st == xbc_pkg::ST_IDLE)
		else $error("internal address reached external bus");
	AST_ADDR_LATCH: assert property (st == xbc_pkg::ST_ADDR |-> pins.ale && pins.rd_n
		&& pins.wr_n ##1 strobe)
		else $error("address phase not followed by strobe");

	COV_WRITE: cover property (st == xbc_pkg::ST_STRB && acc_write && core_ack == 1'b0);
	COV_GAP: cover property (st == xbc_pkg::ST_GAP);
	COV_LOWER: cover property (st == xbc_pkg::ST_ADDR && !acc_upper);
	COV_KEEP: cover property (!enable && pins.ad_keep);
endmodule // xbc_ctrl
`default_nettype wire

/* tb/xbc_sram_model.sv */
// Purpose: external sram on the far side of the multiplexed bus
// Assumes: released high pins read as zero on the wire
// Notes: undriven bus shows the inverse of the last byte unless kept
`timescale 1ns/1ns
`default_nettype none
module xbc_sram_model (
	input wire logic hclk,
	input wire xbc_pkg::xbc_pins_type pins,
	output logic [7:0] ad_in
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr = 16'h0000;
	logic [7:0] last = 8'h00;
	always_ff @(posedge hclk) begin
		if (pins.ale) begin
			addr <= {pins.hi_out & pins.hi_oe, pins.ad_out};
		end
		if (!pins.wr_n) begin
			mem[addr] <= pins.ad_out;
		end
		if (pins.ad_oe != 8'h00) begin
			last <= pins.ad_out;
		end
	end
	always_comb begin
		if (!pins.rd_n) begin
			ad_in = mem[addr];
		end else if (pins.ad_oe != 8'h00) begin
			ad_in = pins.ad_out;
		end else begin
			ad_in = pins.ad_keep ? last : ~last;
		end
	end
endmodule // xbc_sram_model
`default_nettype wire

/* tb/test_external_memory_bus_control.sv */
// Purpose: self-checking bench for the external memory bus control
// Assumes: zero-wait ahb slave, sram model on the bus
// Notes: access time counted in edges from request to ack
`timescale 1ns/1ns
`default_nettype none
module test_external_memory_bus_control;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic hready;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, core_ack;
	logic [31:0] hrdata, rd;
	logic [7:0] core_rdata, ad_in;
	logic [1:0] c;
	logic [2:0] l;
	xbc_pkg::xbc_req_type core_req = '0;
	xbc_pkg::xbc_port_type port_norm = '{8'h3C, 8'h00, 8'h00, 8'h0F, 3'h5, 3'h0};
	xbc_pkg::xbc_pins_type pins;
	int n_mismatch = 0;
	int comparisons = 0;
	int n;
	assign hready = hreadyout;
	xbc_ctrl u_xbc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_req(core_req),
		.core_ack(core_ack), .core_rdata(core_rdata), .port_norm(port_norm),
		.ad_in(ad_in), .pins(pins));
	xbc_sram_model u_xbc_sram_model (.hclk(hclk), .pins(pins), .ad_in(ad_in));
	initial begin
		forever #2 hclk = ~hclk;
	end
	function automatic int ws(input logic [1:0] code);
		return (code == 2'h3) ? 2 : int'(code);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic edge_rdy();
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			i++;
			if (i > 50) begin
				n_mismatch++;
				wrap_up();
			end
			@(posedge hclk);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		edge_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		edge_rdy();
		rd = hrdata;
		// one idle edge so register effects on pins have settled
		@(posedge hclk);
	endtask
	// keep leaves valid up so a following request goes back to back
	task automatic core(input logic w, input logic [15:0] a, input logic [7:0] d, input logic keep);
		time t0;
		t0 = $time;
		core_req <= '{1'b1, w, a, d};
		fork
			@(posedge core_ack);
			repeat (50) @(posedge hclk);
		join_any
		disable fork;
		n = int'(($time - t0) / 4);
		if (n >= 50) begin
			n_mismatch++;
			wrap_up();
		end
		if (!keep) begin
			core_req.valid <= 1'b0;
			@(posedge hclk);
		end
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, xbc_pkg::ADDR_CTRL_A, 32'h0);
		chk(rd, 32'h0);
		chk(pins.hi_oe, port_norm.c_dir);
		chk(pins.ad_oe, port_norm.a_dir);
		chk(pins.ctl_oe, port_norm.g_dir);
		core(1'b0, 16'h3000, 8'h00, 1'b0);
		chk(n, 1);
		ahb(1'b1, xbc_pkg::ADDR_CTRL_B, 32'h87);
		chk(pins.ad_keep, 1'b1);
		ahb(1'b0, xbc_pkg::ADDR_CTRL_B, 32'h0);
		chk(rd, 32'h87);
		ahb(1'b1, xbc_pkg::ADDR_CTRL_B, 32'h0);
		chk(pins.ad_keep, 1'b0);
		ahb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			ahb(1'b1, xbc_pkg::ADDR_CTRL_A, {24'h0, 4'h8, c, ~c});
			chk(pins.ctl_oe, 3'h7);
			core(1'b1, {14'h0C00, c}, {6'h28, c}, 1'b0);
			chk(n, 3 + ws(c));
			core(1'b0, {14'h0C00, c}, 8'h00, 1'b0);
			chk(core_rdata, {6'h28, c});
		end
		ahb(1'b0, xbc_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h1C);
		core(1'b1, 16'h3010, 8'h11, 1'b1);
		chk(n, 5);
		core(1'b0, 16'h3010, 8'h00, 1'b0);
		chk(n, 6);
		chk(core_rdata, 8'h11);
		for (int i = 2; i < 8; i++) begin
			l = 3'(i);
			ahb(1'b1, xbc_pkg::ADDR_CTRL_A, {24'h0, 1'b1, l, 4'h8});
			core(1'b0, {l, 13'h0}, 8'h00, 1'b0);
			chk(n, 5);
			core(1'b0, {l, 13'h0} - 16'h1, 8'h00, 1'b0);
			chk(n, 3);
		end
		core(1'b0, 16'h21FF, 8'h00, 1'b0);
		chk(n, 1);
		ahb(1'b1, xbc_pkg::ADDR_CTRL_B, 32'h80);
		core(1'b1, 16'h3020, 8'h5A, 1'b0);
		chk(pins.ad_oe, 8'h00);
		chk(pins.ad_out, 8'h5A);
		for (int i = 0; i < 8; i++) begin
			ahb(1'b1, xbc_pkg::ADDR_CTRL_B, {29'h0, 3'(i)});
			chk(pins.hi_oe, ((i == 7) ? 8'h00 : 8'hFF >> i) | port_norm.c_dir);
		end
		ahb(1'b1, xbc_pkg::ADDR_CTRL_B, 32'h2);
		core(1'b1, 16'h4001, 8'h55, 1'b0);
		core(1'b0, 16'hC001, 8'h00, 1'b0);
		chk(core_rdata, 8'h55);
		wrap_up();
	end
endmodule // test_external_memory_bus_control
`default_nettype wire
